// ---- design/sav_defs.vh ----
// Purpose: Constants for the service-acknowledge context block
// Assumes: Included by bare name
// Notes: Byte offsets are index times four on the register bus
`ifndef SAV_DEFS_VH
`define SAV_DEFS_VH
// ----------------------------------------
// Register indices (printed offsets)
// ----------------------------------------
`define SAV_IDX_PVEC 8'h40
`define SAV_IDX_MVEC 8'h41
`define SAV_IDX_MFLG 8'h4c
`define SAV_IDX_MOPT 8'h50
`define SAV_IDX_CHSEL 8'h51
`define SAV_IDX_IRQST 8'h52
`define SAV_IDX_IRQMSK 8'h53
`define SAV_IDX_CTX 8'h54
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define SAV_DSR_BIT 7
`define SAV_CTS_BIT 6
`define SAV_RI_BIT 5
`define SAV_CD_BIT 4
`define SAV_CODE_NONE 3'h0
`define SAV_CODE_MODEM 3'h1
`define SAV_CODE_SM 3'h4
`define SAV_CODE_PIPE 3'h5
`define SAV_CODE_BOTH 3'h6
`define SAV_RST_BYTE 8'h00
`define SAV_RST_NIB 4'h0
// Synchroniser reset: ack pins idle high, lines and engine requests idle low
`define SAV_SYNC_IDLE 9'h007
`define SAV_IRQ_MODEM 0
`define SAV_IRQ_PAR 1
`define SAV_IRQ_CTX 2
`endif

// ---- design/sav_core.v ----
// Purpose: Service-acknowledge context, modem change flags and vector codes
// Assumes: One clock; async pins and modem lines synchronised here
// Notes: Registers on classic Wishbone, one byte per aligned word
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "sav_defs.vh"
module sav_core #(
    parameter NSYNC_W = 2
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    // Acknowledge pins (active low, asynchronous)
    input wire service_ack_pin_n_i,
    input wire modem_ack_pin_n_i,
    input wire parallel_ack_pin_n_i,
    // Modem lines and parallel engine requests (asynchronous)
    input wire [3:0] modem_lines_i,
    input wire par_sm_req_i,
    input wire par_pipe_req_i,
    // Host data bus drive
    output reg [7:0] host_data_bus_o,
    output reg host_data_bus_oe_o,
    // Request pins and context
    output wire modem_request_pin_n_o,
    output wire parallel_request_pin_n_o,
    output wire ack_context_o,
    output reg [1:0] serviced_channel_o,
    output wire irq_o
);

    // ----------------------------------------
    // Synchronisers: pins are foreign to clk_i
    // ----------------------------------------
    localparam NS = 9;
    wire [NS-1:0] raw_w;
    reg [NS-1:0] s1_r;
    reg [NS-1:0] s2_r;
    assign raw_w = {par_pipe_req_i, par_sm_req_i, modem_lines_i,
                    parallel_ack_pin_n_i, modem_ack_pin_n_i, service_ack_pin_n_i};

    // Two-stage sync; reset to idle levels so no request shows after reset
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= `SAV_SYNC_IDLE;
            s2_r <= `SAV_SYNC_IDLE;
        end
        else
        begin
            s1_r <= raw_w;
            s2_r <= s1_r;
        end
    end

    wire gen_ack_n_w = s2_r[0];
    wire mod_ack_n_w = s2_r[1];
    wire par_ack_n_w = s2_r[2];
    wire [3:0] lines_w = s2_r[6:3];
    wire sm_req_w = s2_r[7];
    wire pipe_req_w = s2_r[8];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire [7:0] idx_w = adr_i[9:2];
    reg ack_r;
    wire req_w = cyc_i & stb_i & ~ack_r;
    wire wr_w = req_w & we_i & sel_i[0];
    assign ack_o = ack_r;

    // Index match shared by all write strobes
    function hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // Single-wait ack; ack drops the cycle after it was given
    always @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= req_w;
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    reg [3:0] mopt_r;   // Change detect enables: DSR,CTS,RI,CD
    reg [7:0] chsel_r;  // Channel select; poll copy lands here
    reg [2:0] irq_st_r;
    reg [2:0] irq_msk_r;
    reg poll_ctx_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mopt_r <= `SAV_RST_NIB;
            chsel_r <= `SAV_RST_BYTE;
            irq_msk_r <= 3'h0;
        end
        else if (wr_w)
        begin
            if (hit(idx_w, `SAV_IDX_MOPT))
                mopt_r <= dat_i[7:4];
            if (hit(idx_w, `SAV_IDX_CHSEL))
                chsel_r <= dat_i[7:0];
            if (hit(idx_w, `SAV_IDX_IRQMSK))
                irq_msk_r <= dat_i[2:0];
        end
    end

    // ----------------------------------------
    // Modem change detection
    // ----------------------------------------
    reg [3:0] lines_q_r;
    reg [3:0] mflg_r;
    wire [3:0] edge_w = (lines_w ^ lines_q_r) & mopt_r;
    wire flg_clr_w = wr_w & hit(idx_w, `SAV_IDX_MFLG) & ack_context_o;

    // Set beats clear so an edge during the clear is kept
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lines_q_r <= `SAV_RST_NIB;
            mflg_r <= `SAV_RST_NIB;
        end
        else
        begin
            lines_q_r <= lines_w;
            mflg_r <= (mflg_r & ~(flg_clr_w ? dat_i[7:4] : 4'h0)) | edge_w;
        end
    end

    wire modem_req_w = |mflg_r;
    assign modem_request_pin_n_o = ~modem_req_w;
    wire par_req_w = sm_req_w | pipe_req_w | modem_req_w;
    assign parallel_request_pin_n_o = ~par_req_w;

    // ----------------------------------------
    // Vector codes
    // ----------------------------------------
    wire [2:0] mcode_w = modem_req_w ? `SAV_CODE_MODEM : `SAV_CODE_NONE;
    reg [2:0] pcode_w;

    // Engine sources outrank the modem group on the parallel vector
    always @*
    begin
        case ({sm_req_w, pipe_req_w})
            2'b11: pcode_w = `SAV_CODE_BOTH;
            2'b10: pcode_w = `SAV_CODE_SM;
            2'b01: pcode_w = `SAV_CODE_PIPE;
            default: pcode_w = modem_req_w ? `SAV_CODE_MODEM : `SAV_CODE_NONE;
        endcase
    end

    wire [7:0] mvec_w = {5'h00, mcode_w};
    wire [7:0] pvec_w = {5'h00, pcode_w};
    wire [7:0] mflg_byte_w = {mflg_r, 4'h0};

    // ----------------------------------------
    // Context state machine
    // ----------------------------------------
    localparam ST_NORM = 2'd0;
    localparam ST_HWACK = 2'd1;
    localparam ST_POLL = 2'd2;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    wire pin_act_w = ~gen_ack_n_w | (~mod_ack_n_w & modem_req_w) |
                     (~par_ack_n_w & par_req_w);
    // Poll copy: any write to channel select while a request pends
    wire poll_w = wr_w & hit(idx_w, `SAV_IDX_CHSEL) & (modem_req_w | par_req_w);
    wire ctx_end_w = wr_w & hit(idx_w, `SAV_IDX_CTX) & dat_i[0];

    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_NORM:
            begin
                if (pin_act_w)
                    st_nxt = ST_HWACK;
                else if (poll_w)
                    st_nxt = ST_POLL;
            end
            ST_HWACK:
            begin
                if (gen_ack_n_w & mod_ack_n_w & par_ack_n_w)
                    st_nxt = ST_NORM;
            end
            ST_POLL:
            begin
                if (ctx_end_w)
                    st_nxt = ST_NORM;
            end
            default: st_nxt = ST_NORM;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            st_r <= ST_NORM;
        else
            st_r <= st_nxt;
    end

    assign ack_context_o = (st_r != ST_NORM);

    // Serviced channel latched on entry: select write data for a poll, zero for a pin ack
    always @(posedge clk_i)
    begin
        if (rst_i)
            serviced_channel_o <= 2'h0;
        else if (st_r == ST_NORM && st_nxt == ST_POLL)
            serviced_channel_o <= dat_i[1:0];
        else if (st_r == ST_NORM && st_nxt == ST_HWACK)
            serviced_channel_o <= 2'h0;
    end

    // ----------------------------------------
    // Host data bus vector drive
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            host_data_bus_o <= `SAV_RST_BYTE;
            host_data_bus_oe_o <= 1'b0;
        end
        else if (~mod_ack_n_w & modem_req_w)
        begin
            host_data_bus_o <= mvec_w;
            host_data_bus_oe_o <= 1'b1;
        end
        else if (~par_ack_n_w & par_req_w)
        begin
            host_data_bus_o <= pvec_w;
            host_data_bus_oe_o <= 1'b1;
        end
        else
        begin
            host_data_bus_o <= `SAV_RST_BYTE;
            host_data_bus_oe_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    reg ctx_q_r;
    wire [2:0] ev_w = {ack_context_o & ~ctx_q_r, |pcode_w & ~par_ack_n_w, |edge_w};
    wire st_clr_w = wr_w & hit(idx_w, `SAV_IDX_IRQST);

    // Write-one-to-clear; a same-cycle event wins
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_st_r <= 3'h0;
            ctx_q_r <= 1'b0;
        end
        else
        begin
            ctx_q_r <= ack_context_o;
            irq_st_r <= (irq_st_r & ~(st_clr_w ? dat_i[2:0] : 3'h0)) | ev_w;
        end
    end

    assign irq_o = |(irq_st_r & irq_msk_r);

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    reg [7:0] rd_w;
    always @*
    begin
        case (idx_w)
            `SAV_IDX_PVEC: rd_w = pvec_w;
            `SAV_IDX_MVEC: rd_w = mvec_w;
            `SAV_IDX_MFLG: rd_w = mflg_byte_w;
            `SAV_IDX_MOPT: rd_w = {mopt_r, 4'h0};
            `SAV_IDX_CHSEL: rd_w = chsel_r;
            `SAV_IDX_IRQST: rd_w = {5'h00, irq_st_r};
            `SAV_IDX_IRQMSK: rd_w = {5'h00, irq_msk_r};
            `SAV_IDX_CTX: rd_w = {6'h00, st_r};
            default: rd_w = `SAV_RST_BYTE;
        endcase
    end

    // Read data registered with the ack
    always @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (req_w)
            dat_o <= {24'h00_0000, rd_w};
    end

endmodule // sav_core

// ---- verification/sav_core_asserts.sv ----
// Purpose: Port checks for sav_core
// Assumes: One clock, sync active-high reset
// Notes: Bound from the testbench file
`timescale 1ns/1ps
module sav_core_asserts (
    // Bus
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Host pins
    input wire service_ack_pin_n_i,
    input wire modem_ack_pin_n_i,
    input wire [7:0] host_data_bus_o,
    input wire host_data_bus_oe_o,
    input wire modem_request_pin_n_o,
    input wire ack_context_o
);
    // ------
    // Properties
    // ------
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Read data judged at the ack edge, address still held by the master
    wire rd_ack = ack_o && !we_i;
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_flg; rd_ack && adr_i == 10'h130 |-> dat_o[3:0] == 4'h0; endproperty
    a_flg: assert property (p_flg) else $error("flag low bits");
    property p_mvec; rd_ack && adr_i == 10'h104 |-> dat_o[7:1] == 7'h00; endproperty
    a_mvec: assert property (p_mvec) else $error("modem code");
    property p_pvec; rd_ack && adr_i == 10'h100 |-> dat_o[7:0] inside {[0:1], [4:6]}; endproperty
    a_pvec: assert property (p_pvec) else $error("parallel code");
    property p_oe; host_data_bus_oe_o |-> host_data_bus_o[7:3] == 5'h00; endproperty
    a_oe: assert property (p_oe) else $error("vector high bits");
    property p_ctx; $fell(service_ack_pin_n_i) |-> ##[1:5] ack_context_o; endproperty
    a_ctx: assert property (p_ctx) else $error("no context");
    sequence s_mack; $fell(modem_ack_pin_n_i) && !modem_request_pin_n_o; endsequence
    property p_mbus; s_mack |-> ##[1:6] host_data_bus_oe_o && host_data_bus_o == 8'h01; endproperty
    a_mbus: assert property (p_mbus) else $error("modem vector");
    property p_mctx; s_mack |-> ##[1:5] ack_context_o; endproperty
    a_mctx: assert property (p_mctx) else $error("no modem context");
    // Main scenarios reached
    c_mack: cover property (s_mack);
    c_ctx: cover property ($fell(service_ack_pin_n_i));
    c_oe: cover property ($rose(host_data_bus_oe_o));
endmodule // sav_core_asserts

// ---- verification/sav_host_model.sv ----
// Purpose: Host model driving the acknowledge pins
// Assumes: Pins move just after a rising edge
// Notes: Caller acks only while the matching request is low
`timescale 1ns/1ps
module sav_host_model (
    // Clock
    input wire clk_i,
    // Acknowledge pins, active low
    output wire service_ack_pin_n_o,
    output wire modem_ack_pin_n_o,
    output wire parallel_ack_pin_n_o
);
    // ------
    // Pin driver, idle high from time zero
    // ------
    reg [2:0] pins_r = 3'b111;
    assign {service_ack_pin_n_o, modem_ack_pin_n_o, parallel_ack_pin_n_o} = pins_r;
    task automatic drive(input [2:0] pins_n);
    begin
        @(posedge clk_i);
        pins_r <= pins_n;
    end
    endtask
endmodule // sav_host_model

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for sav_core
// Assumes: Classic Wishbone master, host model on the ack pins
// Notes: Fixed waits cover the two-flop pin latency plus one register
`timescale 1ns/1ps
module testbench;
    reg clk_i, rst_i, cyc_i, stb_i, we_i, par_sm_req_i, par_pipe_req_i;
    reg [3:0] sel_i;
    reg [3:0] lanes;
    reg [9:0] adr_i;
    reg [31:0] dat_i;
    reg [3:0] modem_lines_i;
    reg [7:0] v;
    wire [31:0] dat_o;
    wire [7:0] bus;
    wire [1:0] chan;
    wire ack_o, svc_n, mdm_n, par_n, oe, mreq_n, preq_n, ctx, irq;
    integer error_cnt, checks_done, i;
    // ------
    // Design, host model and clock; byte lanes follow lanes per cycle
    // ------
    sav_core dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .service_ack_pin_n_i(svc_n), .modem_ack_pin_n_i(mdm_n),
        .parallel_ack_pin_n_i(par_n), .modem_lines_i(modem_lines_i),
        .par_sm_req_i(par_sm_req_i), .par_pipe_req_i(par_pipe_req_i),
        .host_data_bus_o(bus), .host_data_bus_oe_o(oe), .modem_request_pin_n_o(mreq_n),
        .parallel_request_pin_n_o(preq_n), .ack_context_o(ctx),
        .serviced_channel_o(chan), .irq_o(irq));
    sav_host_model host_u (.clk_i(clk_i), .service_ack_pin_n_o(svc_n),
        .modem_ack_pin_n_o(mdm_n), .parallel_ack_pin_n_o(par_n));
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input [7:0] seen, input [7:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    // One classic cycle, released once ack is seen at an edge or after 16 more edges
    task automatic wb(input [7:0] idx, input w, input [7:0] wd, output [7:0] rdat);
        integer n;
    begin
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, lanes, idx, 2'b00,
                                                      24'h00_0000, wd};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 16)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        chk({7'h00, ack_o}, 8'h01);
        rdat = dat_o[7:0];
        {cyc_i, stb_i, we_i} <= 3'b000;
    end
    endtask
    task automatic wr(input [7:0] idx, input [7:0] wd);
        wb(idx, 1'b1, wd, v);
    endtask
    task automatic rd(input [7:0] idx, input [7:0] exp);
    begin
        wb(idx, 1'b0, 8'h00, v);
        chk(v, exp);
    end
    endtask
    task automatic report_and_stop;
    begin
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    // Hang guard, far beyond the few hundred cycles expected
    initial
    begin
        tick(4000);
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    // Reset, then the scenarios in order
    initial
    begin
        {rst_i, cyc_i, stb_i, we_i, par_sm_req_i, par_pipe_req_i} = 6'h20;
        {adr_i, dat_i, modem_lines_i} = 46'h0;
        sel_i = 4'h0;
        lanes = 4'hf;
        error_cnt = 0;
        checks_done = 0;
        tick(3);
        rst_i <= 1'b0;
        rd(8'h40, 8'h00);
        rd(8'h41, 8'h00);
        rd(8'h4c, 8'h00);
        rd(8'h3f, 8'h00);
        chk({6'h00, mreq_n, preq_n}, 8'h03);
        // A write without byte lane 0 must leave the mask alone
        lanes = 4'he;
        wr(8'h53, 8'h07);
        lanes = 4'hf;
        rd(8'h53, 8'h00);
        // Each modem line in turn, its flag cleared inside a general ack
        wr(8'h50, 8'hf0);
        wr(8'h53, 8'h01);
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge clk_i);
            modem_lines_i[i] <= 1'b1;
            tick(6);
            chk({7'h00, irq}, 8'h01);
            chk({6'h00, mreq_n, preq_n}, 8'h00);
            rd(8'h4c, 8'h10 << i);
            rd(8'h40, 8'h01);
            host_u.drive(3'b011);
            tick(6);
            rd(8'h54, 8'h01);
            wr(8'h4c, 8'hf0);
            wr(8'h52, 8'h07);
            host_u.drive(3'b111);
            chk({7'h00, irq}, 8'h00);
        end
        // Masked event, then modem ack answered on the host bus
        @(posedge clk_i);
        modem_lines_i[3] <= 1'b0;
        tick(6);
        wr(8'h53, 8'h00);
        tick(2);
        chk({7'h00, irq}, 8'h00);
        wr(8'h53, 8'h01);
        tick(2);
        chk({7'h00, irq}, 8'h01);
        host_u.drive(3'b101);
        tick(6);
        chk(bus, 8'h01);
        chk({oe, 5'h00, chan}, 8'h80);
        rd(8'h41, 8'h01);
        wr(8'h4c, 8'h80);
        wr(8'h52, 8'h07);
        host_u.drive(3'b111);
        tick(6);
        chk({7'h00, oe}, 8'h00);
        // Every parallel source pattern, answered on the parallel ack
        for (i = 1; i < 4; i = i + 1)
        begin
            @(posedge clk_i);
            {par_pipe_req_i, par_sm_req_i} <= i[1:0];
            tick(5);
            rd(8'h40, 8'h03 + i[7:0]);
            chk({6'h00, mreq_n, preq_n}, 8'h02);
            host_u.drive(3'b110);
            tick(6);
            chk(bus, 8'h03 + i[7:0]);
            host_u.drive(3'b111);
            tick(6);
        end
        // Poll copy while requests pend, ended by register
        wr(8'h51, 8'h02);
        rd(8'h54, 8'h02);
        chk({6'h00, chan}, 8'h02);
        wr(8'h54, 8'h01);
        rd(8'h54, 8'h00);
        report_and_stop;
    end
endmodule // testbench
bind sav_core sav_core_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .service_ack_pin_n_i(service_ack_pin_n_i), .modem_ack_pin_n_i(modem_ack_pin_n_i),
    .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
    .modem_request_pin_n_o(modem_request_pin_n_o), .ack_context_o(ack_context_o));
